// ---- src/wdtc_consts.vh ----
// constants of the watchdog timer control block
`ifndef WDTC_CONSTS_VH
`define WDTC_CONSTS_VH

// register port
`define WDTC_ADDR_W        4
`define WDTC_DATA_W        8
`define WDTC_OFS_CTRL      4'h0
`define WDTC_OFS_STATUS    4'h1
`define WDTC_OFS_CLEAR     4'h2
`define WDTC_OFS_ENABLE    4'h3

// control/status bit map
`define WDTC_BIT_FLAG      7
`define WDTC_BIT_IRQEN     6
`define WDTC_BIT_SEL3      5
`define WDTC_BIT_UNLOCK    4
`define WDTC_BIT_RSTEN     3
`define WDTC_SEL_LO_HI     2
`define WDTC_SEL_LO_LO     0

// event status bits
`define WDTC_EV_W          2
`define WDTC_EV_TIMEOUT    0
`define WDTC_EV_RESET      1

// reset values
`define WDTC_CTRL_RST      8'h00
`define WDTC_EV_RST        2'h0
`define WDTC_SEL_RST       4'h0

// fuse encoding
`define WDTC_FUSE_PROG     1'b0

// time-out select
`define WDTC_SEL_W         4
`define WDTC_SEL_MAX       4'h9
`define WDTC_BASE_CYCLES   21'h000800
`define WDTC_CNT_W         21

// change window length in processor cycles
`define WDTC_UNLOCK_CYCLES 3'h4
`define WDTC_UNLOCK_W      3

`endif

// ---- src/wdtc_osc_sync.v ----
// two-stage synchroniser and rising edge detector for the slow oscillator
`timescale 1ns/1ps
module wdtc_osc_sync (
  // clock and reset
  input  wire clk_sys,
  input  wire reset_n,
  // oscillator level and tick out
  input  wire oscIn,
  output reg  tickOut
);

  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  // stage1 is read only by stage2
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
      tickOut    <= 1'b0;
    end else begin
      stage1_reg <= oscIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      tickOut    <= stage2_reg & ~stage3_reg; // RULE_19
    end
  end

endmodule

// ---- src/wdtc_counter.v ----
// time-out counter stepped by synchronised oscillator ticks
`timescale 1ns/1ps
`include "wdtc_consts.vh"
module wdtc_counter (
  // clock and reset
  input  wire                     clk_sys,
  input  wire                     reset_n,
  // control
  input  wire                     tick,
  input  wire                     run,
  input  wire                     restart,
  input  wire [`WDTC_SEL_W-1:0]   sel,
  // event
  output reg                      expire
);

  reg [`WDTC_CNT_W-1:0] count_reg;

  // reserved codes fall back to the longest period
  function [`WDTC_CNT_W-1:0] limitOf;
    input [`WDTC_SEL_W-1:0] code;
    begin
      if (code > `WDTC_SEL_MAX)
        limitOf = `WDTC_BASE_CYCLES << `WDTC_SEL_MAX; // RULE_18
      else
        limitOf = `WDTC_BASE_CYCLES << code; // RULE_11
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= {`WDTC_CNT_W{1'b0}};
      expire    <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (restart || !run) begin
        count_reg <= {`WDTC_CNT_W{1'b0}}; // RULE_15
      end else if (tick) begin
        // a shorter period chosen mid-count expires on the next tick
        if (count_reg >= limitOf(sel) - 21'h000001) begin
          count_reg <= {`WDTC_CNT_W{1'b0}};
          expire    <= 1'b1; // RULE_14
        end else begin
          count_reg <= count_reg + 21'h000001;
        end
      end
    end
  end

endmodule

// ---- src/wdtc_top.v ----
// watchdog timer control: register port, mode decode, change window, events
//
// Overview of operation
// (RULE_01) time-out in interrupt mode sets flag; vector or written one clears it
// (RULE_02) interrupt request while global enable, irq enable and flag all set
// (RULE_03) mode from fuse, reset enable, irq enable: stopped/irq/reset/irq-then-reset
// (RULE_04) programmed fuse (0) forces reset mode; unprogrammed fuse reads 1
// (RULE_05) combined mode: vector clears irq enable and flag, leaving reset mode
// (RULE_06) combined mode: second time-out with flag still pending resets system
// (RULE_07) software re-arms irq enable after each interrupt, outside the handler
// (RULE_08) clearing reset enable or changing select only while unlock bit set
// (RULE_09) unlock bit clears itself four processor cycles after being written
// (RULE_10) reset enable reads set and cannot clear while watchdog reset flag set
// (RULE_11) time-out is 2048 oscillator cycles shifted left by select code 0..9
// (RULE_12) bits: flag 7, irq enable 6, select msb 5, unlock 4, reset enable 3
// (RULE_13) software restarts counter before changing select to avoid early time-out
// (RULE_14) counter steps on the separate slow oscillator, acts at time-out count
// (RULE_15) restart command zeroes counter; software issues it before time-out
// (RULE_16) software writes unlock+reset enable, then new values within four cycles
// (RULE_17) programmed fuse locks reset enable at one and irq enable at zero
// (RULE_18) reserved select codes act as the longest defined period
// (RULE_19) time-out is synchronised into processor clock before it acts
`timescale 1ns/1ps
`include "wdtc_consts.vh"
module wdtc_top (
  // clock and reset
  input  wire                    clk_sys,
  input  wire                    reset_n,
  // register port
  input  wire [`WDTC_ADDR_W-1:0] regAddr,
  input  wire [`WDTC_DATA_W-1:0] regWdata,
  input  wire                    regWrite,
  input  wire                    regRead,
  output reg  [`WDTC_DATA_W-1:0] regRdata,
  // processor core
  input  wire                    globalIrqEnable,
  input  wire                    irqVectorTaken,
  input  wire                    restartCmd,
  output reg                     timeoutIrqReq,
  // fuse and reset cause
  input  wire                    alwaysOnFuse,
  input  wire                    watchdogResetFlag,
  output reg                     systemResetReq,
  // slow oscillator
  input  wire                    wdOscIn,
  // event interrupt
  output reg                     eventIrq
);

  ////////////////////////////////////////////////////////////////////////
  // state
  reg                        timeoutIrqFlag_reg;
  reg                        timeoutIrqEnable_reg;
  reg                        resetOnTimeoutEnable_reg;
  reg [`WDTC_SEL_W-1:0]      timeoutSelect_reg;
  reg                        changeUnlock_reg;
  reg [`WDTC_UNLOCK_W-1:0]   unlockCount_reg;
  reg [`WDTC_EV_W-1:0]       eventStatus_reg;
  reg [`WDTC_EV_W-1:0]       eventEnable_reg;

  reg                        timeoutIrqFlag_next;
  reg                        timeoutIrqEnable_next;
  reg                        resetOnTimeoutEnable_next;
  reg [`WDTC_SEL_W-1:0]      timeoutSelect_next;
  reg                        changeUnlock_next;
  reg [`WDTC_UNLOCK_W-1:0]   unlockCount_next;
  reg [`WDTC_EV_W-1:0]       eventStatus_next;
  reg                        resetPulse_next;
  reg                        timeoutEvent_next;

  wire                       oscTick;
  wire                       expire;
  wire                       fuseProgrammed;
  wire                       rstEnEff;
  wire                       irqEnEff;
  wire                       running;
  wire [`WDTC_DATA_W-1:0]    ctrlView;
  wire                       wrCtrl;
  wire                       wrClear;
  wire                       wrEnable;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  assign fuseProgrammed = (alwaysOnFuse == `WDTC_FUSE_PROG); // RULE_04
  // reset enable also reads set under the fuse or the reset flag
  assign rstEnEff = resetOnTimeoutEnable_reg | fuseProgrammed | watchdogResetFlag; // RULE_10
  assign irqEnEff = timeoutIrqEnable_reg & ~fuseProgrammed; // RULE_17
  assign running  = rstEnEff | irqEnEff; // RULE_03

  assign wrCtrl   = regWrite && (regAddr == `WDTC_OFS_CTRL);
  assign wrClear  = regWrite && (regAddr == `WDTC_OFS_CLEAR);
  assign wrEnable = regWrite && (regAddr == `WDTC_OFS_ENABLE);

  assign ctrlView = {timeoutIrqFlag_reg,
                     irqEnEff,
                     timeoutSelect_reg[3],
                     changeUnlock_reg,
                     rstEnEff,
                     timeoutSelect_reg[2:0]}; // RULE_12

  ////////////////////////////////////////////////////////////////////////
  // oscillator and counter
  wdtc_osc_sync uSync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .oscIn   (wdOscIn),
    .tickOut (oscTick)
  );

  wdtc_counter uCounter (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick    (oscTick),
    .run     (running),
    .restart (restartCmd),
    .sel     (timeoutSelect_reg),
    .expire  (expire)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state
  always @* begin
    timeoutIrqFlag_next       = timeoutIrqFlag_reg;
    timeoutIrqEnable_next     = timeoutIrqEnable_reg;
    resetOnTimeoutEnable_next = resetOnTimeoutEnable_reg;
    timeoutSelect_next        = timeoutSelect_reg;
    changeUnlock_next         = changeUnlock_reg;
    unlockCount_next          = unlockCount_reg;
    eventStatus_next          = eventStatus_reg;
    resetPulse_next           = 1'b0;
    timeoutEvent_next         = 1'b0;

    // change window closes on its own
    if (changeUnlock_reg) begin
      if (unlockCount_reg == {`WDTC_UNLOCK_W{1'b0}})
        changeUnlock_next = 1'b0; // RULE_09
      else
        unlockCount_next = unlockCount_reg - 3'h1; // RULE_09
    end

    // vector execution clears flag, and irq enable in combined mode
    if (irqVectorTaken) begin
      timeoutIrqFlag_next = 1'b0; // RULE_01
      if (rstEnEff)
        timeoutIrqEnable_next = 1'b0; // RULE_05
    end

    // software write to control/status
    if (wrCtrl) begin
      if (regWdata[`WDTC_BIT_FLAG])
        timeoutIrqFlag_next = 1'b0; // RULE_01
      timeoutIrqEnable_next = regWdata[`WDTC_BIT_IRQEN] & ~fuseProgrammed; // RULE_17
      if (regWdata[`WDTC_BIT_RSTEN])
        resetOnTimeoutEnable_next = 1'b1;
      else if (changeUnlock_reg && !watchdogResetFlag)
        resetOnTimeoutEnable_next = 1'b0; // RULE_08
      if (changeUnlock_reg)
        timeoutSelect_next = {regWdata[`WDTC_BIT_SEL3],
                              regWdata[`WDTC_SEL_LO_HI:`WDTC_SEL_LO_LO]}; // RULE_08
      // a write with unlock low is the second step and shuts the window
      if (regWdata[`WDTC_BIT_UNLOCK]) begin
        changeUnlock_next = 1'b1;
        unlockCount_next  = `WDTC_UNLOCK_CYCLES - 3'h1; // RULE_09
      end else begin
        changeUnlock_next = 1'b0;
      end
    end

    // reset flag pins reset enable high
    if (watchdogResetFlag || fuseProgrammed)
      resetOnTimeoutEnable_next = 1'b1; // RULE_10

    // time-out action; a set beats any clear in the same cycle
    if (expire) begin
      timeoutEvent_next = 1'b1;
      if (fuseProgrammed) begin
        resetPulse_next = 1'b1; // RULE_04
      end else if (irqEnEff && !rstEnEff) begin
        timeoutIrqFlag_next = 1'b1; // RULE_01
      end else if (!irqEnEff && rstEnEff) begin
        resetPulse_next = 1'b1; // RULE_03
      end else if (irqEnEff && rstEnEff) begin
        if (timeoutIrqFlag_reg)
          resetPulse_next = 1'b1; // RULE_06
        else
          timeoutIrqFlag_next = 1'b1; // RULE_03
      end
    end

    // sticky event status, set wins over clear
    if (wrClear)
      eventStatus_next = eventStatus_reg & ~regWdata[`WDTC_EV_W-1:0];
    if (timeoutEvent_next)
      eventStatus_next[`WDTC_EV_TIMEOUT] = 1'b1;
    if (resetPulse_next)
      eventStatus_next[`WDTC_EV_RESET] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timeoutIrqFlag_reg       <= 1'b0;
      timeoutIrqEnable_reg     <= 1'b0;
      resetOnTimeoutEnable_reg <= 1'b0;
      timeoutSelect_reg        <= `WDTC_SEL_RST;
      changeUnlock_reg         <= 1'b0;
      unlockCount_reg          <= {`WDTC_UNLOCK_W{1'b0}};
      eventStatus_reg          <= `WDTC_EV_RST;
      eventEnable_reg          <= `WDTC_EV_RST;
      systemResetReq           <= 1'b0;
      timeoutIrqReq            <= 1'b0;
      eventIrq                 <= 1'b0;
    end else begin
      timeoutIrqFlag_reg       <= timeoutIrqFlag_next;
      timeoutIrqEnable_reg     <= timeoutIrqEnable_next;
      resetOnTimeoutEnable_reg <= resetOnTimeoutEnable_next;
      timeoutSelect_reg        <= timeoutSelect_next;
      changeUnlock_reg         <= changeUnlock_next;
      unlockCount_reg          <= unlockCount_next;
      eventStatus_reg          <= eventStatus_next;
      if (wrEnable)
        eventEnable_reg <= regWdata[`WDTC_EV_W-1:0];
      systemResetReq <= resetPulse_next;
      // request follows the registered flag by one cycle
      timeoutIrqReq  <= globalIrqEnable & irqEnEff & timeoutIrqFlag_reg; // RULE_02
      eventIrq       <= |(eventStatus_reg & eventEnable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= `WDTC_CTRL_RST;
    end else if (regRead) begin
      case (regAddr)
        `WDTC_OFS_CTRL:   regRdata <= ctrlView; // RULE_12
        `WDTC_OFS_STATUS: regRdata <= {6'h00, eventStatus_reg};
        `WDTC_OFS_ENABLE: regRdata <= {6'h00, eventEnable_reg};
        default:          regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

// ---- bench/wdtc_top_asserts.sv ----
// port checker for the watchdog timer control block
`timescale 1ns/1ps
`include "wdtc_consts.vh"
module wdtc_checker (
  // clock and reset
  input wire                    clk_sys,
  input wire                    reset_n,
  // register port
  input wire [`WDTC_ADDR_W-1:0] regAddr,
  input wire                    regRead,
  input wire [`WDTC_DATA_W-1:0] regRdata,
  // core, fuse and reset request
  input wire                    globalIrqEnable,
  input wire                    irqVectorTaken,
  input wire                    restartCmd,
  input wire                    timeoutIrqReq,
  input wire                    alwaysOnFuse,
  input wire                    watchdogResetFlag,
  input wire                    systemResetReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_read_idle_zero: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) > 4'h3 |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_fuse_locks: assert property ($past(regRead) && $past(regAddr) == 4'h0 && !alwaysOnFuse
    |-> regRdata[3] && !regRdata[6])
    else $error("fuse lock not shown in control view");
  a_flag_forces_rsten: assert property ($past(regRead) && $past(regAddr) == 4'h0
    && $past(watchdogResetFlag) |-> regRdata[3])
    else $error("reset enable not forced by reset flag");
  a_irq_needs_gie: assert property (timeoutIrqReq |-> $past(globalIrqEnable))
    else $error("interrupt request without global enable");
  a_fuse_no_irq: assert property (!alwaysOnFuse |-> !timeoutIrqReq)
    else $error("interrupt request in forced reset mode");
  a_vector_drops: assert property (irqVectorTaken |-> ##2 !timeoutIrqReq)
    else $error("request stays after vector");
  a_reset_one_pulse: assert property (systemResetReq |=> !systemResetReq)
    else $error("reset request longer than one cycle");
  a_restart_quiet: assert property (restartCmd |=> !systemResetReq [*8])
    else $error("reset request right after restart");
endmodule
bind wdtc_top wdtc_checker chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regRead(regRead),
  .regRdata(regRdata), .globalIrqEnable(globalIrqEnable), .irqVectorTaken(irqVectorTaken),
  .restartCmd(restartCmd), .timeoutIrqReq(timeoutIrqReq), .alwaysOnFuse(alwaysOnFuse),
  .watchdogResetFlag(watchdogResetFlag), .systemResetReq(systemResetReq));

// ---- bench/wdtc_core_model.sv ----
// processor core and slow oscillator stand-in
`timescale 1ns/1ps
module wdtc_core_model (
  // clock and reset
  input  wire clk_sys,
  input  wire reset_n,
  // vector service
  input  wire serviceEn,
  input  wire timeoutIrqReq,
  output reg  irqVectorTaken,
  // slow oscillator
  output reg  wdOscIn
);
  reg  [1:0] oscDiv;
  reg  [1:0] guard;
  wire       takeVec = serviceEn && timeoutIrqReq && guard == 2'h0;
  ////////////////////////////////////////
  // far faster than the real oscillator, to keep runs short
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oscDiv  <= 2'h0;
      wdOscIn <= 1'b0;
    end else begin
      oscDiv <= oscDiv + 2'h1;
      if (oscDiv[0]) wdOscIn <= ~wdOscIn;
    end
  end
  // guard: request lags the flag, so no second vector on its tail
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      guard          <= 2'h0;
      irqVectorTaken <= 1'b0;
    end else begin
      irqVectorTaken <= takeVec;
      guard          <= takeVec ? 2'h3 : guard - (guard != 2'h0);
    end
  end
endmodule

// ---- bench/test_watchdog_timer_control.sv ----
// self-checking bench for the watchdog timer control block
`timescale 1ns/1ps
module test_watchdog_timer_control;
  reg        clk_sys = 1'b0;
  reg        reset_n = 1'b0;
  reg  [3:0] regAddr = 4'h0;
  reg  [7:0] regWdata = 8'h00;
  reg        regWrite = 1'b0;
  reg        regRead = 1'b0;
  reg        globalIrqEnable = 1'b1;
  reg        restartCmd = 1'b0;
  reg        alwaysOnFuse = 1'b1;
  reg        watchdogResetFlag = 1'b0;
  reg        serviceEn = 1'b0;
  wire [7:0] regRdata;
  wire       irqVectorTaken, timeoutIrqReq, systemResetReq, wdOscIn, eventIrq;
  integer    errTotal = 0;
  integer    compares = 0;
  integer    cycles = 0;
  integer    n;
  always #5 clk_sys = ~clk_sys;
  wdtc_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .globalIrqEnable(globalIrqEnable), .irqVectorTaken(irqVectorTaken),
    .restartCmd(restartCmd), .timeoutIrqReq(timeoutIrqReq), .alwaysOnFuse(alwaysOnFuse),
    .watchdogResetFlag(watchdogResetFlag), .systemResetReq(systemResetReq),
    .wdOscIn(wdOscIn), .eventIrq(eventIrq));
  wdtc_core_model model_u (.clk_sys(clk_sys), .reset_n(reset_n), .serviceEn(serviceEn),
    .timeoutIrqReq(timeoutIrqReq), .irqVectorTaken(irqVectorTaken), .wdOscIn(wdOscIn));
  ////////////////////////////////////////
  task results;
    begin
      if (errTotal == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        errTotal = errTotal + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 chk(regRdata, exp);
    end
  endtask
  task kick;
    begin
      @(posedge clk_sys);
      restartCmd <= 1'b1;
      @(posedge clk_sys);
      restartCmd <= 1'b0;
    end
  endtask
  // which: 0 interrupt request, 1 reset request; bounded wait
  task waitFor(input integer which, output integer cnt);
    begin
      cnt = 0;
      do begin
        @(posedge clk_sys);
        #1 cnt = cnt + 1;
      end while ((which ? systemResetReq : timeoutIrqReq) !== 1'b1 && cnt < 20000);
      chk({7'h0, cnt < 20000}, 8'h01);
    end
  endtask
  // ticks arrive every 4 clocks; allow sync and pulse lag
  task span(input integer cnt, input integer ticks);
    chk({7'h0, cnt >= ticks * 4 - 2 && cnt <= ticks * 4 + 8}, 8'h01);
  endtask
  task doReset(input fuse, input flag);
    begin
      reset_n           <= 1'b0;
      alwaysOnFuse      <= fuse;
      watchdogResetFlag <= flag;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      errTotal = errTotal + 1;
      results;
    end
  end
  ////////////////////////////////////////
  initial begin
    doReset(1'b1, 1'b0);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h9, 8'h00);
    wr(4'h0, 8'h08);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h08);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h18);
    repeat (5) @(posedge clk_sys);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h08);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    // interrupt mode
    wr(4'h3, 8'h03);
    wr(4'h0, 8'h40);
    kick;
    waitFor(0, n);
    rd(4'h0, 8'hc0);
    rd(4'h1, 8'h01);
    chk({7'h0, eventIrq}, 8'h01);
    globalIrqEnable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({7'h0, timeoutIrqReq}, 8'h00);
    globalIrqEnable <= 1'b1;
    wr(4'h0, 8'hc0);
    rd(4'h0, 8'h40);
    wr(4'h2, 8'h03);
    rd(4'h1, 8'h00);
    chk({7'h0, eventIrq}, 8'h00);
    // combined mode: serviced once, then left pending
    wr(4'h0, 8'h48);
    kick;
    serviceEn <= 1'b1;
    waitFor(0, n);
    repeat (4) @(posedge clk_sys);
    rd(4'h0, 8'h08);
    serviceEn <= 1'b0;
    wr(4'h0, 8'h48);
    waitFor(0, n);
    waitFor(1, n);
    rd(4'h1, 8'h03);
    // programmed fuse forces reset mode
    doReset(1'b0, 1'b0);
    rd(4'h0, 8'h08);
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h08);
    kick;
    waitFor(1, n);
    span(n, 2048);
    kick;
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h09);
    kick;
    waitFor(1, n);
    span(n, 4096);
    // reset flag pins reset enable
    doReset(1'b1, 1'b1);
    rd(4'h0, 8'h08);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h08);
    watchdogResetFlag <= 1'b0;
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    results;
  end
endmodule
